/* File: tlip_pkg.sv */
// Package of constants and types for the two-level interrupt priority block
package tlip_pkg;

    // ------------------------------------------------------------
    // Sources, indexed in polling order (index 0 polled first)
    // ------------------------------------------------------------
    localparam int NSRC = 11;
    localparam int SRC_W = 4;
    localparam logic [3:0] SRC_SUPPLY = 4'h0;
    localparam logic [3:0] SRC_WATCHDOG = 4'h1;
    localparam logic [3:0] SRC_EXT0 = 4'h2;
    localparam logic [3:0] SRC_CONV = 4'h3;
    localparam logic [3:0] SRC_TIMER_A = 4'h4;
    localparam logic [3:0] SRC_EXT1 = 4'h5;
    localparam logic [3:0] SRC_TIMER_B = 4'h6;
    localparam logic [3:0] SRC_SYNC_SER = 4'h7;
    localparam logic [3:0] SRC_UART = 4'h8;
    localparam logic [3:0] SRC_TIMER_C = 4'h9;
    localparam logic [3:0] SRC_INTERVAL = 4'ha;

    // ------------------------------------------------------------
    // Enable register layout and reset values
    // ------------------------------------------------------------
    localparam int GLOBAL_EN_BIT = 7;
    localparam logic [7:0] PRIMARY_EN_RST = 8'h00;
    localparam logic [10:0] PRIO_RST = 11'h000;
    localparam logic HIGH_LEVEL = 1'b1;
    localparam logic LOW_LEVEL = 1'b0;

    // ------------------------------------------------------------
    // Vector addresses
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_SUPPLY = 16'h0043;
    localparam logic [15:0] VEC_WATCHDOG = 16'h005b;
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_CONV = 16'h0033;
    localparam logic [15:0] VEC_TIMER_A = 16'h000b;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TIMER_B = 16'h001b;
    localparam logic [15:0] VEC_SYNC_SER = 16'h003b;
    localparam logic [15:0] VEC_UART = 16'h0023;
    localparam logic [15:0] VEC_TIMER_C = 16'h002b;
    localparam logic [15:0] VEC_INTERVAL = 16'h0053;

    typedef enum logic [1:0] {
        TLIP_IDLE,
        TLIP_WAIT_ACK
    } tlip_state_e;

    function automatic logic [15:0] tlip_vector(input logic [3:0] idx);
        logic [15:0] v;
        v = VEC_INTERVAL;
        case (idx)
            SRC_SUPPLY: v = VEC_SUPPLY;
            SRC_WATCHDOG: v = VEC_WATCHDOG;
            SRC_EXT0: v = VEC_EXT0;
            SRC_CONV: v = VEC_CONV;
            SRC_TIMER_A: v = VEC_TIMER_A;
            SRC_EXT1: v = VEC_EXT1;
            SRC_TIMER_B: v = VEC_TIMER_B;
            SRC_SYNC_SER: v = VEC_SYNC_SER;
            SRC_UART: v = VEC_UART;
            SRC_TIMER_C: v = VEC_TIMER_C;
            default: v = VEC_INTERVAL;
        endcase
        return v;
    endfunction

endpackage

/* File: tlip_sel_if.sv */
// Interface between the arbiter top and its per-level picker
`timescale 1ns/1ps
interface tlip_sel_if;
    import tlip_pkg::*;
    logic [NSRC-1:0] req;
    logic found;
    logic [SRC_W-1:0] idx;
    modport picker (input req, output found, output idx);
    modport user (output req, input found, input idx);
endinterface

/* File: tlip_pick.sv */
// Fixed-order picker: lowest index among asserted requests
`timescale 1ns/1ps
module tlip_pick (
    tlip_sel_if.picker sel
);
    import tlip_pkg::*;

    always_comb begin
        sel.found = 1'b0;
        sel.idx = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (sel.req[i]) begin
                sel.found = 1'b1;
                sel.idx = SRC_W'(i);
            end
        end
    end
endmodule

/* File: tlip_top.sv */
// Two-level interrupt priority arbiter and vector generator
// Behaviour
// (R1) A source is forwarded only while its individual enable bit is set.
// (R2) Global enable, bit 7 of primary enable, cleared blocks every source.
// (R3) Each source has a software priority bit choosing one of two levels.
// (R4) Priority bit 1 means high level, 0 means low level.
// (R5) A pending enabled high request preempts a running low routine.
// (R6) Simultaneous high and low requests: high is granted first.
// (R7) No new request at a level while that level's routine runs.
// (R8) Same-level ties resolve in fixed polling order, supply monitor first.
// (R9) Watchdog is polled ahead of external request 0.
// (R10) Grant makes the core push the program counter then load the vector.
// (R11) Vectors: ext0 0003, timer a 000b, ext1 0013, timer b 001b, uart 0023.
// (R12) Vectors: timer c 002b, conv 0033, sync 003b, supply 0043, etc.
`timescale 1ns/1ps
module tlip_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [tlip_pkg::NSRC-1:0] src_req,
    input wire logic [tlip_pkg::NSRC-1:0] src_enable,
    input wire logic global_irq_enable,
    input wire logic [tlip_pkg::NSRC-1:0] src_priority,
    input wire logic grant_ack,
    input wire logic routine_end,
    output logic irq_request,
    output logic [15:0] irq_vector,
    output logic [tlip_pkg::SRC_W-1:0] irq_source,
    output logic irq_level,
    output logic high_active,
    output logic low_active
);
    import tlip_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        tlip_state_e st;
        logic req;
        logic [15:0] vec;
        logic [SRC_W-1:0] src;
        logic lvl;
        logic hi_act;
        logic lo_act;
    } tlip_s;

    tlip_s s_q;
    tlip_s s_d;

    logic [NSRC-1:0] live;
    logic [NSRC-1:0] hi_req;
    logic [NSRC-1:0] lo_req;

    tlip_sel_if hi_sel ();
    tlip_sel_if lo_sel ();

    // ------------------------------------------------------------
    // Request qualification
    // ------------------------------------------------------------
    always_comb begin
        live = src_req & src_enable; // R1
        if (!global_irq_enable) begin
            live = '0; // R2
        end
        hi_req = live & src_priority; // R3 R4
        lo_req = live & ~src_priority; // R3 R4
    end

    assign hi_sel.req = hi_req;
    assign lo_sel.req = lo_req;

    // Index order puts watchdog before external 0
    tlip_pick u_hi (.sel(hi_sel)); // R8 R9
    tlip_pick u_lo (.sel(lo_sel)); // R8 R9

    // ------------------------------------------------------------
    // Arbitration and handshake with the core
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            TLIP_IDLE: begin
                if (hi_sel.found && !s_q.hi_act) begin // R5 R6 R7
                    s_d.req = 1'b1;
                    s_d.src = hi_sel.idx;
                    s_d.vec = tlip_vector(hi_sel.idx); // R11 R12
                    s_d.lvl = HIGH_LEVEL;
                    s_d.st = TLIP_WAIT_ACK;
                end else if (lo_sel.found && !s_q.hi_act
                             && !s_q.lo_act) begin // R7
                    s_d.req = 1'b1;
                    s_d.src = lo_sel.idx;
                    s_d.vec = tlip_vector(lo_sel.idx); // R11 R12
                    s_d.lvl = LOW_LEVEL;
                    s_d.st = TLIP_WAIT_ACK;
                end
            end
            TLIP_WAIT_ACK: begin
                if (grant_ack) begin // R10
                    s_d.req = 1'b0;
                    if (s_q.lvl) begin
                        s_d.hi_act = 1'b1;
                    end else begin
                        s_d.lo_act = 1'b1;
                    end
                    s_d.st = TLIP_IDLE;
                end
            end
            default: begin
                s_d.st = TLIP_IDLE;
            end
        endcase
        // Return ends the innermost running level
        if (routine_end && s_q.st == TLIP_IDLE) begin
            if (s_q.hi_act) begin
                s_d.hi_act = 1'b0;
            end else begin
                s_d.lo_act = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '{st: TLIP_IDLE, req: 1'b0, vec: 16'h0000,
                     src: 4'h0, lvl: 1'b0, hi_act: 1'b0, lo_act: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign irq_request = s_q.req;
    assign irq_vector = s_q.vec;
    assign irq_source = s_q.src;
    assign irq_level = s_q.lvl;
    assign high_active = s_q.hi_act;
    assign low_active = s_q.lo_act;
endmodule

/* File: tlip_chk.sv */
// Port checker for the two-level interrupt arbiter
`timescale 1ns/1ps
module tlip_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [10:0] src_req,
    input wire logic [10:0] src_enable,
    input wire logic global_irq_enable,
    input wire logic [10:0] src_priority,
    input wire logic grant_ack,
    input wire logic routine_end,
    input wire logic irq_request,
    input wire logic [15:0] irq_vector,
    input wire logic [3:0] irq_source,
    input wire logic irq_level,
    input wire logic high_active,
    input wire logic low_active
);
    localparam logic [15:0] VT [11] = '{16'h0043, 16'h005b, 16'h0003,
        16'h0033, 16'h000b, 16'h0013, 16'h001b, 16'h003b, 16'h0023,
        16'h002b, 16'h0053};
    wire [10:0] q = src_req & src_enable & {11{global_irq_enable}};
    wire [10:0] below = (11'h1 << irq_source) - 11'h1;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    req_hold_a: assert property (irq_request && !grant_ack |=> irq_request
        && $stable(irq_vector)) else $error("request not held");
    req_drop_a: assert property (irq_request && grant_ack |=> !irq_request
        && (irq_level ? high_active : low_active)) else $error("bad ack");
    vec_map_a: assert property (irq_request |-> irq_vector == VT[irq_source])
        else $error("wrong vector");
    gate_a: assert property ($rose(irq_request)
        |-> ($past(q) & (11'h1 << irq_source)) != 11'h0)
        else $error("unqualified grant");
    level_a: assert property ($rose(irq_request)
        |-> irq_level == (($past(src_priority) & (11'h1 << irq_source))
        != 11'h0)) else $error("level");
    poll_order_a: assert property ($rose(irq_request) |-> ((irq_level ?
        $past(q & src_priority) : $past(q & ~src_priority)) & below) == 11'h0)
        else $error("polling order");
    high_first_a: assert property ($rose(irq_request) && !irq_level
        |-> $past(q & src_priority) == 11'h0) else $error("low before high");
    level_busy_a: assert property ($rose(irq_request) |-> !$past(high_active)
        && (irq_level || !$past(low_active))) else $error("same level nested");
    end_clr_a: assert property (routine_end && !irq_request && high_active
        |=> !high_active) else $error("high routine not ended");
    cover property ($rose(irq_request) && irq_level && low_active);
    cover property (routine_end && low_active && !high_active);
    cover property ($rose(irq_request) && irq_source == 4'ha);
endmodule
bind tlip_top tlip_chk u_chk (.*);

/* File: tlip_core.sv */
// Behavioural core: acknowledges a request with grant_ack, later when slow
`timescale 1ns/1ps
module tlip_core (
    input wire logic mclk,
    input wire logic rst,
    input wire logic irq_request,
    input wire logic slow,
    output logic grant_ack
);
    logic [1:0] wait_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            grant_ack <= 1'b0;
            wait_q <= 2'h0;
        end else begin
            // Ack at once, or after three cycles when slow
            grant_ack <= irq_request && !grant_ack
                && (wait_q == 2'h3 || !slow);
            wait_q <= (irq_request && !grant_ack) ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule

/* File: two_level_interrupt_priority_tb.sv */
// Self-checking bench for the two-level interrupt arbiter
`timescale 1ns/1ps
module two_level_interrupt_priority_tb;
    import tlip_pkg::*;
    localparam logic [15:0] VT [11] = '{16'h0043, 16'h005b, 16'h0003,
        16'h0033, 16'h000b, 16'h0013, 16'h001b, 16'h003b, 16'h0023,
        16'h002b, 16'h0053};
    logic mclk = 0, rst = 1, global_irq_enable = 0, routine_end = 0, slow = 0;
    logic [10:0] src_req = 0, src_enable = 0, src_priority = 0;
    logic grant_ack, irq_request, irq_level, high_active, low_active;
    logic [15:0] irq_vector;
    logic [3:0] irq_source;
    logic [20:0] exp_q [$];
    int n_mismatch = 0, cmp_count = 0;
    always #2 mclk = ~mclk;
    tlip_top u_tlip_top (.*);
    tlip_core u_tlip_core (.*);
    task automatic check(input logic [20:0] seen, input logic [20:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Each accepted grant is compared with the oldest note
    always @(negedge mclk) begin
        if (irq_request === 1'b1 && grant_ack === 1'b1 && exp_q.size() > 0)
            check({irq_vector, irq_source, irq_level}, exp_q.pop_front());
    end
    task automatic expect_grant(input int s, input logic lvl);
        exp_q.push_back({VT[s], 4'(s), lvl});
        for (int k = 0; k < 40 && exp_q.size() > 0; k++) begin
            @(posedge mclk);
            #1;
        end
        if (exp_q.size() > 0) check(21'h0, exp_q.pop_front());
    endtask
    task automatic fin;
        routine_end = 1;
        @(posedge mclk);
        #1 routine_end = 0;
    endtask
    task automatic quiet;
        repeat (8) begin
            @(posedge mclk);
            #1 check(21'(irq_request), 21'h0);
        end
    endtask
    initial begin
        #40000 n_mismatch++;
        give_verdict;
    end
    initial begin
        void'($urandom(32'h476e16e4));
        repeat (6) @(posedge mclk);
        #1 rst = 0;
        global_irq_enable = 1;
        // Only one enabled source among many requests; random level
        for (int i = 0; i < 11; i++) begin
            src_priority = 11'($urandom);
            slow = 1'($urandom);
            src_enable = 11'h1 << i;
            src_req = 11'h7ff;
            expect_grant(i, src_priority[i]);
            src_req = 0;
            fin;
        end
        // Everything at once: high one first, then polling order
        src_enable = 11'h7ff;
        src_priority = 11'h400;
        src_req = 11'h7ff;
        expect_grant(10, 1);
        src_req[10] = 0;
        fin;
        for (int i = 0; i < 10; i++) begin
            expect_grant(i, 0);
            src_req[i] = 0;
            fin;
        end
        // Nesting over a low routine, same level held off
        src_priority = 0;
        src_req = 11'h400;
        expect_grant(10, 0);
        src_priority = 11'h001;
        src_req = 11'h201;
        expect_grant(0, 1);
        check(21'({high_active, low_active}), 21'h3);
        src_req[0] = 0;
        fin;
        quiet;
        check(21'({high_active, low_active}), 21'h1);
        fin;
        expect_grant(9, 0);
        src_req = 0;
        fin;
        // Global enable off, then individual enables off
        global_irq_enable = 0;
        src_req = 11'h7ff;
        quiet;
        global_irq_enable = 1;
        src_enable = 0;
        quiet;
        check(21'({high_active, low_active}), 21'h0);
        give_verdict;
    end
endmodule
